// *** inc/isr_pkg.sv ***
// Constants and types for the inertial sample output register block.
// Assumes an AXI4-Lite master and a sensing front end giving raw samples.
// Overview of operation
// - Rate weight per count is 0.00625, 0.025 or 0.1 deg/s by model.
// - Rate high word is twos complement; full range reads +/-20000 counts.
// - Low rate word adds 16 resolution bits below high word; 32-bit value.
// - X rate low word at index 0x04, high word at index 0x06.
// - Y rate low word at index 0x08, high word at index 0x0A.
// - Z rate low word at index 0x0C, high word at index 0x0E.
// - Acceleration words form 32-bit value, limits 0x7D000000 and 0x83000000.
// - Acceleration high word at 1.25 mg per count, +/-32000 at 40 g.
// - Acceleration axes are the same three axes as the rate outputs.
// - Acceleration words at indices 0x10/0x12, 0x14/0x16, 0x18/0x1A, read-only.
package isr_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_AXES = 3;
   localparam int NUM_WORDS = 6;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 6;
   localparam int HALF_W = 16;

   localparam logic [5:0] IDX_X_RATE_LOW = 6'h04;
   localparam logic [5:0] IDX_X_RATE_HIGH = 6'h06;
   localparam logic [5:0] IDX_Y_RATE_LOW = 6'h08;
   localparam logic [5:0] IDX_Y_RATE_HIGH = 6'h0A;
   localparam logic [5:0] IDX_Z_RATE_LOW = 6'h0C;
   localparam logic [5:0] IDX_Z_RATE_HIGH = 6'h0E;
   localparam logic [5:0] IDX_X_ACCEL_LOW = 6'h10;
   localparam logic [5:0] IDX_X_ACCEL_HIGH = 6'h12;
   localparam logic [5:0] IDX_Y_ACCEL_LOW = 6'h14;
   localparam logic [5:0] IDX_Y_ACCEL_HIGH = 6'h16;
   localparam logic [5:0] IDX_Z_ACCEL_LOW = 6'h18;
   localparam logic [5:0] IDX_Z_ACCEL_HIGH = 6'h1A;
   localparam logic [5:0] IDX_CTRL = 6'h20;
   localparam logic [5:0] IDX_STATUS = 6'h22;

   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_STEP = 16'h0001;

   // Weight per count in deg/s for each model
   localparam real KG_MODEL0 = 0.00625;
   localparam real KG_MODEL1 = 0.025;
   localparam real KG_MODEL2 = 0.1;
   localparam int MODEL_MAX = 2;
   localparam int SHIFT_PER_MODEL = 2;
   // Acceleration weight per count in mg
   localparam real ACCEL_WEIGHT_MG = 1.25;

   localparam logic [31:0] RATE_POS_LIMIT = 32'h4E200000;
   localparam logic [31:0] RATE_NEG_LIMIT = 32'hB1E00000;
   localparam logic [31:0] ACCEL_POS_LIMIT = 32'h7D000000;
   localparam logic [31:0] ACCEL_NEG_LIMIT = 32'h83000000;
   localparam logic [2:0] ACCEL_SHIFT = 3'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Word order: x, y, z rate, then x, y, z acceleration
   typedef struct packed {
      logic [NUM_WORDS-1:0][31:0] word;
   } isr_samples_t;

   typedef enum logic [1:0] {
      WS_IDLE = 2'h1,
      WS_RESP = 2'h2
   } isr_wstate_t;

   typedef enum logic [1:0] {
      RS_IDLE = 2'h1,
      RS_DATA = 2'h2
   } isr_rstate_t;

   typedef struct packed {
      isr_samples_t samp;
      logic ctrl_en;
      logic [15:0] count;
      isr_wstate_t ws;
      logic aw_got;
      logic [5:0] aw_idx;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] bresp;
      isr_rstate_t rs;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } isr_state_t;
endpackage : isr_pkg

// *** logic/isr_sample_regs.sv ***
// Sample output registers for rate and acceleration, AXI4-Lite slave.
// Assumes samples arrive with a one-cycle strobe, synchronous to aclk.
`timescale 1ns/100ps
module isr_sample_regs #(
   parameter int MODEL = 0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [isr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [isr_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [isr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [isr_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic sample_strobe,
   input wire isr_pkg::isr_samples_t sample_raw
);
   isr_pkg::isr_state_t st;
   isr_pkg::isr_state_t next_st;
   isr_pkg::isr_samples_t scaled;
   logic [2:0] rate_shift;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic [5:0] wr_idx;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;

   if (MODEL < 0 || MODEL > isr_pkg::MODEL_MAX) begin : g_bad_model
      $error("MODEL out of range");
   end

   assign rate_shift = 3'(MODEL * isr_pkg::SHIFT_PER_MODEL);

   for (genvar i = 0; i < isr_pkg::NUM_WORDS; i++) begin : g_conv
      localparam logic [31:0] POS = (i < isr_pkg::NUM_AXES) ?
         isr_pkg::RATE_POS_LIMIT : isr_pkg::ACCEL_POS_LIMIT;
      localparam logic [31:0] NEG = (i < isr_pkg::NUM_AXES) ?
         isr_pkg::RATE_NEG_LIMIT : isr_pkg::ACCEL_NEG_LIMIT;
      isr_sat_scale #(
         .POS_LIMIT(POS),
         .NEG_LIMIT(NEG)
      ) u_conv (
         .raw(sample_raw.word[i]),
         .shift((i < isr_pkg::NUM_AXES) ? rate_shift : isr_pkg::ACCEL_SHIFT),
         .scaled(scaled.word[i])
      );
   end

   // Sample word slot for an index, or -1 when not a sample register
   function automatic int sample_slot(input logic [5:0] idx);
      int slot;
      slot = -1;
      if (idx >= isr_pkg::IDX_X_RATE_LOW && idx <= isr_pkg::IDX_Z_ACCEL_HIGH && !idx[0]) begin
         slot = int'(idx[5:2]) - 1;
      end
      return slot;
   endfunction : sample_slot

   function automatic logic [31:0] read_word(input isr_pkg::isr_state_t s, input logic [5:0] idx);
      int slot;
      logic [31:0] w;
      slot = sample_slot(idx);
      w = 32'h00000000;
      if (slot >= 0) begin
         if (idx[1]) begin
            w = {16'h0000, s.samp.word[slot][31:16]};
         end else begin
            w = {16'h0000, s.samp.word[slot][15:0]};
         end
      end else if (idx == isr_pkg::IDX_CTRL) begin
         w[isr_pkg::CTRL_EN_BIT] = s.ctrl_en;
      end else if (idx == isr_pkg::IDX_STATUS) begin
         w = {16'h0000, s.count};
      end
      return w;
   endfunction : read_word

   function automatic logic [1:0] read_resp(input logic [5:0] idx);
      logic [1:0] r;
      r = isr_pkg::RESP_DECERR;
      if (sample_slot(idx) >= 0 || idx == isr_pkg::IDX_CTRL || idx == isr_pkg::IDX_STATUS) begin
         r = isr_pkg::RESP_OKAY;
      end
      return r;
   endfunction : read_resp

   assign s_axi_awready = !st.aw_got && st.ws == isr_pkg::WS_IDLE;
   assign s_axi_wready = !st.w_got && st.ws == isr_pkg::WS_IDLE;
   assign s_axi_bvalid = st.ws == isr_pkg::WS_RESP;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.rs == isr_pkg::RS_IDLE;
   assign s_axi_rvalid = st.rs == isr_pkg::RS_DATA;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign wr_idx = st.aw_got ? st.aw_idx : s_axi_awaddr[isr_pkg::IDX_LSB +: isr_pkg::IDX_W];
   assign wr_data = st.w_got ? st.wdata : s_axi_wdata;
   assign wr_strb = st.w_got ? st.wstrb : s_axi_wstrb;

   always_comb begin
      next_st = st;
      // Capture all six words at once from one sample
      if (sample_strobe && st.ctrl_en) begin
         next_st.samp = scaled;
         next_st.count = st.count + isr_pkg::COUNT_STEP;
      end
      if (aw_take) begin
         next_st.aw_got = 1'b1;
         next_st.aw_idx = s_axi_awaddr[isr_pkg::IDX_LSB +: isr_pkg::IDX_W];
      end
      if (w_take) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      case (st.ws)
         isr_pkg::WS_IDLE: begin
            if ((st.aw_got || aw_take) && (st.w_got || w_take)) begin
               next_st.aw_got = 1'b0;
               next_st.w_got = 1'b0;
               next_st.ws = isr_pkg::WS_RESP;
               if (wr_idx == isr_pkg::IDX_CTRL) begin
                  if (wr_strb[0]) begin
                     next_st.ctrl_en = wr_data[isr_pkg::CTRL_EN_BIT];
                  end
                  next_st.bresp = isr_pkg::RESP_OKAY;
               end else if (read_resp(wr_idx) == isr_pkg::RESP_OKAY) begin
                  next_st.bresp = isr_pkg::RESP_SLVERR;
               end else begin
                  next_st.bresp = isr_pkg::RESP_DECERR;
               end
            end
         end
         isr_pkg::WS_RESP: begin
            if (s_axi_bready) begin
               next_st.ws = isr_pkg::WS_IDLE;
            end
         end
         default: begin
            next_st.ws = isr_pkg::WS_IDLE;
         end
      endcase
      case (st.rs)
         isr_pkg::RS_IDLE: begin
            if (ar_take) begin
               next_st.rdata = read_word(st, s_axi_araddr[isr_pkg::IDX_LSB +: isr_pkg::IDX_W]);
               next_st.rresp = read_resp(s_axi_araddr[isr_pkg::IDX_LSB +: isr_pkg::IDX_W]);
               next_st.rs = isr_pkg::RS_DATA;
            end
         end
         isr_pkg::RS_DATA: begin
            if (s_axi_rready) begin
               next_st.rs = isr_pkg::RS_IDLE;
            end
         end
         default: begin
            next_st.rs = isr_pkg::RS_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.ctrl_en <= isr_pkg::CTRL_EN_RESET;
         st.count <= isr_pkg::COUNT_RESET;
         st.ws <= isr_pkg::WS_IDLE;
         st.rs <= isr_pkg::RS_IDLE;
         st.bresp <= isr_pkg::RESP_OKAY;
         st.rresp <= isr_pkg::RESP_OKAY;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_capture;
      sample_strobe && st.ctrl_en;
   endsequence

   sequence s_no_capture;
      !(sample_strobe && st.ctrl_en);
   endsequence

   AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("bvalid dropped early");
   AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("rvalid dropped early");
   AST_RATE_POS: assert property (s_capture |=>
      $signed(st.samp.word[0]) <= $signed(isr_pkg::RATE_POS_LIMIT))
      else $error("rate above range");
   AST_RATE_NEG: assert property (s_capture |=>
      $signed(st.samp.word[2]) >= $signed(isr_pkg::RATE_NEG_LIMIT))
      else $error("rate below range");
   AST_ACCEL_RANGE: assert property (s_capture |=>
      $signed(st.samp.word[3]) <= $signed(isr_pkg::ACCEL_POS_LIMIT)
      && $signed(st.samp.word[3]) >= $signed(isr_pkg::ACCEL_NEG_LIMIT))
      else $error("accel out of range");
   AST_SCALE_SHIFT: assert property (s_capture ##0
      ($signed(sample_raw.word[1]) == 32'sh00000000) |=> st.samp.word[1] == 32'h00000000)
      else $error("zero rate not zero");
   AST_COHERENT: assert property (s_capture |=> st.samp == $past(scaled))
      else $error("words not from one sample");
   AST_WRITE_IGNORED: assert property (s_no_capture ##0
      (st.ws == isr_pkg::WS_IDLE && (st.aw_got || aw_take) && (st.w_got || w_take))
      |=> $stable(st.samp))
      else $error("write changed a sample");
   AST_HIGH_WORD: assert property (ar_take ##0
      (s_axi_araddr[isr_pkg::IDX_LSB +: isr_pkg::IDX_W] == isr_pkg::IDX_X_RATE_HIGH) ##0
      s_no_capture |=> s_axi_rdata == {16'h0000, st.samp.word[0][31:16]}
      && s_axi_rresp == isr_pkg::RESP_OKAY) else $error("x rate high word wrong");
   AST_ACCEL_LOW: assert property (ar_take ##0
      (s_axi_araddr[isr_pkg::IDX_LSB +: isr_pkg::IDX_W] == isr_pkg::IDX_Z_ACCEL_LOW) ##0
      s_no_capture |=> s_axi_rdata == {16'h0000, st.samp.word[5][15:0]})
      else $error("z accel low word wrong");
endmodule : isr_sample_regs

// *** logic/isr_sat_scale.sv ***
// Scales one raw sample by a right shift and clamps it to the output range.
// Assumes raw input in the finest weight divided by 2^16 per count.
`timescale 1ns/100ps
module isr_sat_scale #(
   parameter logic [31:0] POS_LIMIT = isr_pkg::RATE_POS_LIMIT,
   parameter logic [31:0] NEG_LIMIT = isr_pkg::RATE_NEG_LIMIT
) (
   input wire logic [31:0] raw,
   input wire logic [2:0] shift,
   output logic [31:0] scaled
);
   logic signed [31:0] shifted;

   always_comb begin
      shifted = $signed(raw) >>> shift;
      if (shifted > $signed(POS_LIMIT)) begin
         scaled = POS_LIMIT;
      end else if (shifted < $signed(NEG_LIMIT)) begin
         scaled = NEG_LIMIT;
      end else begin
         scaled = shifted;
      end
   end
endmodule : isr_sat_scale

// *** sim/inertial_sample_output_regs_tb_top.sv ***
// Testbench top: feeds samples, reads every word back, checks bus answers.
// Assumes isr_pkg, isr_sample_regs and isr_host_model are compiled first.
`timescale 1ns/100ps
`define CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module inertial_sample_output_regs_tb_top;
   localparam int MODEL = 0;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, sample_strobe, en;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] n_samp;
   isr_pkg::isr_samples_t sample_raw, held;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   isr_sample_regs #(.MODEL(MODEL)) isr_sample_regs_inst (.*);
   isr_host_model isr_host_model_inst (.*);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic wrap_up();
      $display("Counts: checks=%0d mismatches=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // Expected 32-bit word: rate words scaled by model, all clamped to full range
   function automatic logic [31:0] exp_val(input int i, input logic [31:0] raw);
      logic signed [31:0] v;
      logic signed [31:0] hi;
      logic signed [31:0] lo;
      v = (i < 3) ? ($signed(raw) >>> (2 * MODEL)) : $signed(raw);
      hi = (i < 3) ? isr_pkg::RATE_POS_LIMIT : isr_pkg::ACCEL_POS_LIMIT;
      lo = (i < 3) ? isr_pkg::RATE_NEG_LIMIT : isr_pkg::ACCEL_NEG_LIMIT;
      if (v > hi) v = hi;
      if (v < lo) v = lo;
      return v;
   endfunction : exp_val

   task automatic push(input isr_pkg::isr_samples_t s);
      sample_raw <= s;
      sample_strobe <= 1'b1;
      @(posedge aclk);
      sample_strobe <= 1'b0;
      sample_raw <= ~s;
      if (en) begin
         held = s;
         n_samp = n_samp + 16'h0001;
      end
      @(posedge aclk);
   endtask : push

   task automatic push_rnd();
      isr_pkg::isr_samples_t s;
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         s.word[i] = seed;
      end
      push(s);
   endtask : push_rnd

   // Words 0..2 rate x,y,z, 3..5 accel x,y,z; low at 16+16i, high 8 above
   task automatic check_all();
      logic [31:0] d;
      logic [1:0] r;
      logic [31:0] e;
      for (int i = 0; i < 6; i++) begin
         e = exp_val(i, held.word[i]);
         isr_host_model_inst.rd(8'(16 + 16 * i), d, r);
         `CHK(d, {16'h0000, e[15:0]})
         `CHK(r, isr_pkg::RESP_OKAY)
         isr_host_model_inst.rd(8'(24 + 16 * i), d, r);
         `CHK(d, {16'h0000, e[31:16]})
      end
      isr_host_model_inst.rd(8'h88, d, r);
      `CHK(d[15:0], n_samp)
   endtask : check_all

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      aresetn = 1'b0;
      sample_strobe = 1'b0;
      sample_raw = '0;
      held = '0;
      en = 1'b1;
      n_samp = 16'h0000;
      seed = 32'h54F27A1A;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check_all();
      $display("Test reset values done");
      push({32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF, 32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF});
      check_all();
      push('0);
      check_all();
      $display("Test range limits done");
      repeat (6) begin
         push_rnd();
         check_all();
      end
      $display("Test random samples done");
      isr_host_model_inst.wr(8'h18, 32'h0000FFFF, r);
      `CHK(r, isr_pkg::RESP_SLVERR)
      isr_host_model_inst.wr(8'h40, 32'h12345678, r);
      `CHK(r, isr_pkg::RESP_SLVERR)
      check_all();
      isr_host_model_inst.rd(8'h14, d, r);
      `CHK(r, isr_pkg::RESP_DECERR)
      `CHK(d, 32'h00000000)
      $display("Test refused accesses done");
      isr_host_model_inst.wr(8'h80, 32'h00000000, r);
      `CHK(r, isr_pkg::RESP_OKAY)
      en = 1'b0;
      push_rnd();
      check_all();
      isr_host_model_inst.wr(8'h80, 32'h00000001, r);
      en = 1'b1;
      push_rnd();
      check_all();
      $display("Test capture enable done");
      wrap_up();
   end
endmodule : inertial_sample_output_regs_tb_top

// *** sim/isr_host_model.sv ***
// Host model: AXI4-Lite master, one read or one write at a time.
// Assumes tasks are entered just after a rising edge of aclk.
`timescale 1ns/100ps
module isr_host_model (
   input wire logic aclk,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [7:0] s_axi_awaddr,
   output logic [2:0] s_axi_awprot,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   output logic [7:0] s_axi_araddr,
   output logic [2:0] s_axi_arprot,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp
);
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {52{1'b1}};
      {s_axi_awprot, s_axi_arprot} = 6'h00;
      {s_axi_bready, s_axi_rready} = 2'h3;
   end
   // Released address and data are inverted, never left at their last value
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // Response ready held back one cycle so the slave must hold its answer
      s_axi_bready <= 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b0;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd
endmodule : isr_host_model
